/* File: core/amp_diag_pkg.sv */
// register map, field layout and timing constants of the amplifier control block
// assumes a single 40 MHz system clock
package amp_diag_pkg;
	localparam logic [6:0] SLAVE_ADDR       = 7'h71;
	localparam logic [7:0] ADDR_STATUS      = 8'h10;
	localparam logic [7:0] ADDR_FAULT       = 8'h11;
	localparam logic [7:0] ADDR_DIAG_RESULT = 8'h12;
	localparam logic [7:0] ADDR_AMP_CONTROL = 8'h13;
	localparam logic [7:0] ADDR_DIAG_CTRL   = 8'h14;
	localparam logic [7:0] RST_AMP_CONTROL  = 8'h78;
	localparam logic [7:0] RST_DIAG_CTRL    = 8'h00;
	localparam int         BIT_SHORTED_LOAD = 7;
	localparam int         BIT_OPEN_LOAD    = 6;
	localparam int         BIT_SHORT_GROUND = 5;
	localparam int         BIT_SHORT_SUPPLY = 4;
	localparam int         BIT_DIAG_RUNNING = 5;
	localparam int         BIT_FAULT_STATE  = 4;
	localparam int         BIT_OVERCURRENT  = 3;
	localparam int         BIT_DIAG_FAULT   = 2;
	localparam int         CLK_HZ           = 40_000_000;
	localparam int         DIAG_TIME_MS     = 260;
	localparam int         DIAG_CYCLES      = DIAG_TIME_MS * (CLK_HZ / 1000);
	typedef enum logic [1:0] {
		DG_IDLE  = 2'b00,
		DG_RUN   = 2'b01,
		DG_PLAY  = 2'b10
	} diag_state_t;
endpackage

/* File: core/amp_load_diag_control_regs.sv */
// i2c register bank and load-diagnostic sequencer of a mono class-d amplifier
// assumes scl and sda arrive asynchronously; analog sense and fault levels are inputs
`timescale 1ns/1ps
module amp_load_diag_control_regs
	import amp_diag_pkg::*;
#(
	parameter int DIAG_LEN = DIAG_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic       sense_shorted,
	input  wire logic       sense_open,
	input  wire logic       sense_gnd,
	input  wire logic       sense_supply,
	input  wire logic       sense_big_cap,
	input  wire logic       flt_overcurrent,
	input  wire logic       flt_dc,
	input  wire logic       flt_overvolt,
	input  wire logic       flt_undervolt,
	input  wire logic       flt_overtemp,
	output logic [1:0]      gain_select,
	output logic [2:0]      power_limit_select,
	output logic            soft_mute,
	output logic            spread_spectrum_enable,
	output logic            switch_freq_select,
	output logic            out_hiz,
	output logic            diag_running_flag
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic scl_s, sda_s;
	pin_sync #(.RESET_VAL(1'b1)) u_scl (.clk(clk), .rst_n(rst_n), .pin(scl), .level(scl_s));
	pin_sync #(.RESET_VAL(1'b1)) u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_in), .level(sda_s));

	// ------------------------------------------------------------
	// i2c slave
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_REG  = 3'b010,
		I_DATA = 3'b011,
		I_READ = 3'b100,
		I_ACK  = 3'b101
	} i2c_state_t;

	i2c_state_t ist_reg, ist_next, iret_reg, iret_next;
	logic       scl_d_reg, sda_d_reg;
	logic [7:0] sh_reg, sh_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] ptr_reg, ptr_next;
	logic       sda_out_reg, sda_out_next;
	logic       wr_stb, rd_stb;
	logic [7:0] wr_data;
	logic       got_ptr_reg, got_ptr_next;
	logic       mack_reg, mack_next;

	logic [7:0] amp_ctrl_reg, amp_ctrl_next;
	logic       diag_dis_reg, diag_dis_next;
	logic [3:0] res_reg, res_next;
	logic       oc_reg, oc_next;
	logic       dfault_reg, dfault_next;
	diag_state_t dst_reg, dst_next;

	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	function automatic logic [7:0] read_mux(input logic [7:0] a);
		case (a)
			ADDR_STATUS:      read_mux = {2'b00, dst_reg == DG_RUN, 5'b0_0000};
			ADDR_FAULT:       read_mux = {4'h0, oc_reg, dfault_reg, 2'b00};
			ADDR_DIAG_RESULT: read_mux = {res_reg, 4'h0};
			ADDR_AMP_CONTROL: read_mux = amp_ctrl_reg;
			ADDR_DIAG_CTRL:   read_mux = {7'h00, diag_dis_reg};
			default:          read_mux = 8'h00;
		endcase
	endfunction

	always_comb begin
		ist_next     = ist_reg;
		iret_next    = iret_reg;
		sh_next      = sh_reg;
		cnt_next     = cnt_reg;
		ptr_next     = ptr_reg;
		sda_out_next = sda_out_reg;
		got_ptr_next = got_ptr_reg;
		mack_next    = mack_reg;
		wr_stb       = 1'b0;
		rd_stb       = 1'b0;
		wr_data      = sh_reg;
		if (start_c) begin
			ist_next     = I_ADDR;
			cnt_next     = 4'h0;
			sda_out_next = 1'b1;
			got_ptr_next = 1'b0;
		end else if (stop_c) begin
			ist_next     = I_IDLE;
			sda_out_next = 1'b1;
		end else begin
			unique case (ist_reg)
				I_IDLE: ;
				I_ADDR, I_REG, I_DATA: begin
					if (scl_rise) begin
						sh_next  = {sh_reg[6:0], sda_s};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == 4'h8) begin
						cnt_next = 4'h0;
						if (ist_reg == I_ADDR) begin
							if (sh_reg[7:1] != SLAVE_ADDR) begin
								ist_next = I_IDLE;
							end else if (sh_reg[0]) begin
								sh_next      = read_mux(ptr_reg);
								rd_stb       = 1'b1;
								sda_out_next = 1'b0;
								ist_next     = I_ACK;
								iret_next    = I_READ;
							end else begin
								sda_out_next = 1'b0;
								ist_next     = I_ACK;
								iret_next    = I_REG;
							end
						end else if (ist_reg == I_REG) begin
							ptr_next     = sh_reg;
							got_ptr_next = 1'b1;
							sda_out_next = 1'b0;
							ist_next     = I_ACK;
							iret_next    = I_DATA;
						end else begin
							wr_stb       = 1'b1;
							sda_out_next = 1'b0;
							ist_next     = I_ACK;
							iret_next    = I_IDLE;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						ist_next     = iret_reg;
						sda_out_next = (iret_reg == I_READ) ? sh_reg[7] : 1'b1;
						cnt_next     = 4'h0;
					end
				end
				I_READ: begin
					if (scl_rise) begin
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == 4'h8) begin
							mack_next = ~sda_s;
						end
					end
					if (scl_fall) begin
						if (cnt_reg == 4'h8) begin
							sda_out_next = 1'b1;
						end else if (cnt_reg == 4'h9) begin
							ist_next = I_IDLE;
						end else begin
							sh_next      = {sh_reg[6:0], 1'b0};
							sda_out_next = sh_reg[6];
						end
					end
				end
				default: ist_next = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ist_reg     <= I_IDLE;
			iret_reg    <= I_IDLE;
			scl_d_reg   <= 1'b1;
			sda_d_reg   <= 1'b1;
			sh_reg      <= 8'h00;
			cnt_reg     <= 4'h0;
			ptr_reg     <= 8'h00;
			sda_out_reg <= 1'b1;
			got_ptr_reg <= 1'b0;
			mack_reg    <= 1'b0;
		end else begin
			ist_reg     <= ist_next;
			iret_reg    <= iret_next;
			scl_d_reg   <= scl_s;
			sda_d_reg   <= sda_s;
			sh_reg      <= sh_next;
			cnt_reg     <= cnt_next;
			ptr_reg     <= ptr_next;
			sda_out_reg <= sda_out_next;
			got_ptr_reg <= got_ptr_next;
			mack_reg    <= mack_next;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_comb begin
		amp_ctrl_next = amp_ctrl_reg;
		diag_dis_next = diag_dis_reg;
		if (wr_stb && ptr_reg == ADDR_AMP_CONTROL) begin
			amp_ctrl_next = wr_data;
		end
		if (wr_stb && ptr_reg == ADDR_DIAG_CTRL) begin
			diag_dis_next = wr_data[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_ctrl_reg <= RST_AMP_CONTROL;
			diag_dis_reg <= RST_DIAG_CTRL[0];
		end else begin
			amp_ctrl_reg <= amp_ctrl_next;
			diag_dis_reg <= diag_dis_next;
		end
	end

	// ------------------------------------------------------------
	// diagnostic sequencer
	// ------------------------------------------------------------
	logic [31:0] dcnt_reg, dcnt_next;
	logic        ov_d_reg, ov_odd_reg, ov_odd_next;
	logic        flt_d_reg;
	logic        boot_reg;
	logic [3:0]  cond_reg, cond_next;
	logic        hiz_reg, hiz_next;
	logic        run_reg;

	wire abort_flt = flt_overtemp | flt_overvolt | flt_undervolt;
	wire ov_end    = ~flt_overvolt & ov_d_reg;
	wire any_flt   = flt_dc | flt_overcurrent | flt_overvolt | flt_undervolt | flt_overtemp;
	// overvoltage counted at its end: a pass started inside it would abort at once
	wire other_rise = (flt_dc | flt_overcurrent | flt_undervolt | flt_overtemp) & ~flt_d_reg;
	wire trigger   = other_rise & ~diag_dis_reg;
	wire ov_trigger = ov_end & ov_odd_reg & ~diag_dis_reg;
	wire pass_end  = (dst_reg == DG_RUN) && dcnt_reg == 32'(DIAG_LEN - 1);
	wire [3:0] sense = {sense_shorted, sense_open, sense_gnd, sense_supply};
	wire shorts    = sense_shorted | sense_gnd | sense_supply;

	always_comb begin
		dst_next    = dst_reg;
		dcnt_next   = dcnt_reg;
		ov_odd_next = ov_end ? ~ov_odd_reg : ov_odd_reg;
		cond_next   = cond_reg;
		unique case (dst_reg)
			DG_IDLE: begin
				if ((boot_reg || ov_trigger) && !diag_dis_reg) begin
					dst_next  = DG_RUN;
					dcnt_next = 32'h0000_0000;
				end else if (!any_flt) begin
					dst_next = DG_PLAY;
				end
			end
			DG_RUN: begin
				dcnt_next = dcnt_reg + 32'h0000_0001;
				if (abort_flt) begin
					dst_next = DG_IDLE;
				end else if (pass_end) begin
					cond_next = sense;
					dcnt_next = 32'h0000_0000;
					if (shorts || sense_big_cap) begin
						dst_next = DG_RUN;
					end else begin
						dst_next = DG_PLAY;
					end
				end
			end
			DG_PLAY: begin
				// a found condition is held while its sense input still shows it
				cond_next = cond_reg & sense;
				if (trigger) begin
					dst_next  = DG_RUN;
					dcnt_next = 32'h0000_0000;
				end else if (any_flt) begin
					dst_next = DG_IDLE;
				end
			end
			default: dst_next = DG_IDLE;
		endcase
		if (diag_dis_reg && dst_reg == DG_RUN) begin
			dst_next = DG_IDLE;
		end
	end

	// result flags: set by condition, cleared only after it went away and a read followed
	always_comb begin
		res_next    = res_reg | cond_reg;
		oc_next     = oc_reg | flt_overcurrent;
		dfault_next = dfault_reg | (|cond_reg);
		if (rd_stb && ptr_reg == ADDR_DIAG_RESULT) begin
			res_next = cond_reg;
		end
		if (rd_stb && ptr_reg == ADDR_FAULT) begin
			oc_next     = flt_overcurrent;
			dfault_next = |cond_reg;
		end
		hiz_next = (dst_next != DG_PLAY) || any_flt;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_reg    <= DG_IDLE;
			dcnt_reg   <= 32'h0000_0000;
			ov_d_reg   <= 1'b0;
			flt_d_reg  <= 1'b0;
			ov_odd_reg <= 1'b0;
			boot_reg   <= 1'b1;
			cond_reg   <= 4'h0;
			res_reg    <= 4'h0;
			oc_reg     <= 1'b0;
			dfault_reg <= 1'b0;
			hiz_reg    <= 1'b1;
			run_reg    <= 1'b0;
		end else begin
			dst_reg    <= dst_next;
			dcnt_reg   <= dcnt_next;
			ov_d_reg   <= flt_overvolt;
			flt_d_reg  <= flt_dc | flt_overcurrent | flt_undervolt | flt_overtemp;
			ov_odd_reg <= ov_odd_next;
			boot_reg   <= 1'b0;
			cond_reg   <= cond_next;
			res_reg    <= res_next;
			oc_reg     <= oc_next;
			dfault_reg <= dfault_next;
			hiz_reg    <= hiz_next;
			run_reg    <= (dst_next == DG_RUN);
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sda_out                = 1'b0;
	assign sda_oe_n               = sda_out_reg;
	assign gain_select            = amp_ctrl_reg[7:6];
	assign power_limit_select     = amp_ctrl_reg[5:3];
	assign soft_mute              = amp_ctrl_reg[2];
	assign spread_spectrum_enable = amp_ctrl_reg[1];
	assign switch_freq_select     = amp_ctrl_reg[0];
	assign out_hiz                = hiz_reg;
	assign diag_running_flag      = run_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence diag_started_s;
		dst_reg != DG_RUN ##1 dst_reg == DG_RUN;
	endsequence

	hiz_during_diag_a: assert property (@(posedge clk) disable iff (!rst_n)
		dst_reg == DG_RUN |-> hiz_reg)
		else $error("outputs not hi-z during diagnostics");
	abort_on_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dst_reg == DG_RUN && abort_flt) |=> dst_reg == DG_IDLE)
		else $error("diagnostics not aborted on fault");
	running_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		diag_running_flag == (dst_reg == DG_RUN))
		else $error("running flag mismatch");
	short_rerun_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pass_end && shorts && !abort_flt && !diag_dis_reg) |=> dst_reg == DG_RUN && dcnt_reg == 0)
		else $error("short did not rerun check");
	open_plays_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pass_end && !shorts && !sense_big_cap && !abort_flt && !diag_dis_reg)
		|=> dst_reg == DG_PLAY)
		else $error("open load blocked play");
	flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		(res_reg[3] && !(rd_stb && ptr_reg == ADDR_DIAG_RESULT)) |=> res_reg[3])
		else $error("result flag cleared without read");
	disable_stops_a: assert property (@(posedge clk) disable iff (!rst_n)
		(diag_dis_reg && dst_reg == DG_PLAY) |=> dst_reg != DG_RUN)
		else $error("diagnostics ran while disabled");
	start_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		diag_started_s |-> dcnt_reg == 0)
		else $error("pass did not start from zero");
	ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && ptr_reg == ADDR_AMP_CONTROL) |=> gain_select == $past(wr_data[7:6]))
		else $error("gain field not written");
endmodule // amp_load_diag_control_regs

/* File: core/pin_sync.sv */
// three-stage synchroniser with agreement filter for an asynchronous pin
// assumes clk is the only clock; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);
	logic [2:0] stage_reg;
	logic       level_reg;
	logic       level_next;

	always_comb begin
		level_next = level_reg;
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg <= {3{RESET_VAL}};
			level_reg <= RESET_VAL;
		end else begin
			stage_reg <= {stage_reg[1:0], pin};
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule // pin_sync

/* File: tb/amp_load_diag_control_regs_tb_top.sv */
// self-checking bench of the amplifier register bank and diagnostic sequencer
// assumes the i2c master model owns scl; sense and fault levels driven here
`timescale 1ns/1ps
module amp_load_diag_control_regs_tb_top;
	import amp_diag_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int DL = 400;
	logic       clk;
	logic       rst_n;
	logic       scl;
	logic       sda_low;
	logic       sda;
	logic       sda_out;
	logic       sda_oe_n;
	logic [4:0] sense;   // shorted, open, gnd, supply, big cap
	logic [4:0] flt;     // overcurrent, dc, overvolt, undervolt, overtemp
	logic [7:0] ctrl_pins;
	logic       out_hiz;
	logic       diag_running_flag;
	int         err_count;
	int         samples_checked;

	assign sda = ~sda_low & (sda_oe_n | sda_out);

	amp_load_diag_control_regs #(.DIAG_LEN(DL)) DUT (
		.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .sense_shorted(sense[4]), .sense_open(sense[3]),
		.sense_gnd(sense[2]), .sense_supply(sense[1]), .sense_big_cap(sense[0]),
		.flt_overcurrent(flt[4]), .flt_dc(flt[3]), .flt_overvolt(flt[2]),
		.flt_undervolt(flt[1]), .flt_overtemp(flt[0]), .gain_select(ctrl_pins[7:6]),
		.power_limit_select(ctrl_pins[5:3]), .soft_mute(ctrl_pins[2]),
		.spread_spectrum_enable(ctrl_pins[1]), .switch_freq_select(ctrl_pins[0]),
		.out_hiz(out_hiz), .diag_running_flag(diag_running_flag));

	i2c_bus_master master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       ok;
		master.access(SLAVE_ADDR, a, d, 1'b0, r, ok);
		check("write ack", ok, 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
		logic [7:0] d;
		logic       ok;
		master.access(SLAVE_ADDR, a, 8'h00, 1'b1, d, ok);
		check("read ack", ok, 1'b1);
		check("read data", d & msk, exp);
	endtask

	task automatic wait_run(input logic v, input int lim, output int n);
		n = 0;
		while (diag_running_flag !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic wait_play();
		int n;
		n = 0;
		while (out_hiz !== 1'b0 && n < 3 * DL) begin
			@(negedge clk);
			n++;
		end
		check("play resumes", n < 3 * DL, 1'b1);
	endtask

	task automatic pulse(input int k);
		flt[k] = 1'b1;
		repeat (2) @(negedge clk);
		flt[k] = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		int n;
		check("ctrl in reset", ctrl_pins, RST_AMP_CONTROL);
		check("hiz in reset", out_hiz, 1'b1);
		rst_n = 1'b1;
		wait_run(1'b1, 8, n);
		check("startup pass", n < 8, 1'b1);
		check("hiz in pass", out_hiz, 1'b1);
		wait_run(1'b0, DL + 20, n);
		check("pass length", n > DL - 5 && n < DL + 5, 1'b1);
		wait_play();
		rd(ADDR_AMP_CONTROL, RST_AMP_CONTROL, 8'hFF);
		rd(ADDR_DIAG_CTRL, RST_DIAG_CTRL, 8'hFF);
		rd(ADDR_DIAG_RESULT, 8'h00, 8'hFF);
	endtask

	task automatic t_ctrl();
		logic [7:0] v;
		logic [7:0] r;
		logic       ok;
		for (int i = 0; i < 8; i++) begin
			v = {i[1:0], 3'(7 - i), i[2:0]};
			wr(ADDR_AMP_CONTROL, v);
			check("ctrl pins", ctrl_pins, v);
			rd(ADDR_AMP_CONTROL, v, 8'hFF);
		end
		master.access(SLAVE_ADDR ^ 7'h01, ADDR_AMP_CONTROL, 8'h78, 1'b0, r, ok);
		check("foreign address", ok, 1'b0);
		check("ctrl kept", ctrl_pins, v);
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h00, 8'hFF);
		wr(ADDR_AMP_CONTROL, RST_AMP_CONTROL);
	endtask

	task automatic t_disable();
		int n;
		wr(ADDR_DIAG_CTRL, 8'hFF);
		rd(ADDR_DIAG_CTRL, 8'h01, 8'hFF);
		pulse(3);
		wait_run(1'b1, 20, n);
		check("no pass when off", n, 8'd20);
		wr(ADDR_DIAG_CTRL, 8'h00);
		wait_play();
	endtask

	task automatic t_open();
		int n;
		sense[3] = 1'b1;
		pulse(3);
		wait_run(1'b1, 20, n);
		check("dc starts pass", n < 20, 1'b1);
		wait_run(1'b0, DL + 20, n);
		repeat (4) @(negedge clk);
		check("open still plays", out_hiz, 1'b0);
		rd(ADDR_DIAG_RESULT, 8'h40, 8'hFF);
		sense[3] = 1'b0;
		rd(ADDR_DIAG_RESULT, 8'h40, 8'hFF);
		rd(ADDR_DIAG_RESULT, 8'h00, 8'hFF);
	endtask

	// short and big capacitance both keep the stage off across passes
	task automatic t_repeat(input int s, input logic [7:0] res);
		int n;
		sense[s] = 1'b1;
		sense[2] = (s == 4);
		flt[4] = 1'b1;
		wait_run(1'b1, 20, n);
		check("fault starts pass", n < 20, 1'b1);
		repeat (2 * DL + DL / 2) @(negedge clk);
		check("still hiz", out_hiz, 1'b1);
		rd(ADDR_FAULT, 8'h08, 8'h08);
		if (s == 4) begin
			rd(ADDR_FAULT, 8'h04, 8'h04);
		end
		rd(ADDR_DIAG_RESULT, res, 8'hFF);
		flt[4] = 1'b0;
		sense = '0;
		wait_play();
		rd(ADDR_DIAG_RESULT, res, 8'hFF);
	endtask

	task automatic t_ov();
		int n;
		pulse(2);
		wait_run(1'b1, 20, n);
		check("first overvolt", n, 8'd20);
		pulse(2);
		wait_run(1'b1, 20, n);
		check("second overvolt", n < 20, 1'b1);
		rd(ADDR_STATUS, 8'h20, 8'h20);
		wait_run(1'b0, DL, n);
		rd(ADDR_STATUS, 8'h00, 8'h20);
		wait_play();
	endtask

	task automatic t_abort(input int k);
		int n;
		pulse(3);
		wait_run(1'b1, 20, n);
		repeat (20) @(negedge clk);
		flt[k] = 1'b1;
		wait_run(1'b0, 4, n);
		check("fault aborts pass", n < 4, 1'b1);
		flt[k] = 1'b0;
		wait_play();
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#2_000_000;
		err_count++;
		results();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		sense = '0;
		flt = '0;
		repeat (3) @(negedge clk);
		t_reset();
		t_ctrl();
		t_disable();
		t_open();
		t_repeat(4, 8'hA0);
		t_repeat(0, 8'h00);
		t_ov();
		t_abort(0);
		t_abort(1);
		results();
	end
endmodule // amp_load_diag_control_regs_tb_top

/* File: tb/i2c_bus_master.sv */
// behavioural i2c bus master: drives scl and pulls sda low, moves on falling clk
// assumes sda is resolved outside with a pull-up; scl stands high between frames
`timescale 1ns/1ps
module i2c_bus_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// ----------------------------------------------------------------
	// bit, byte and frame tasks
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// 8 clocks per bit: 6 low, 2 high; the long low phase lets the slave's
	// ack release settle before scl rises, or it would look like a stop
	task automatic bit_io(input logic b, output logic s);
		repeat (3) @(negedge clk);
		sda_low = ~b;
		repeat (3) @(negedge clk);
		scl = 1'b1;
		repeat (2) @(negedge clk);
		s = sda;
		scl = 1'b0;
	endtask

	task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
			r[i] = s;
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// repeated start waits longer so the slave's ack release lands first
	task automatic start_cond();
		if (!scl) begin
			repeat (4) @(negedge clk);
			sda_low = 1'b0;
			repeat (4) @(negedge clk);
			scl = 1'b1;
		end
		repeat (4) @(negedge clk);
		sda_low = 1'b1;
		repeat (4) @(negedge clk);
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		repeat (2) @(negedge clk);
		sda_low = 1'b1;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		repeat (4) @(negedge clk);
		sda_low = 1'b0;
		repeat (8) @(negedge clk);
	endtask

	task automatic access(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] wd,
		input logic rnw, output logic [7:0] rdata, output logic ok);
		logic [7:0] r;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       n;
		start_cond();
		byte_io({dev, 1'b0}, r, a0);
		byte_io(adr, r, a1);
		if (rnw) begin
			start_cond();
			byte_io({dev, 1'b1}, r, a2);
			byte_io(8'hFF, rdata, n);
		end else begin
			byte_io(wd, r, a2);
		end
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule // i2c_bus_master
